// ===== rtl/can_output_signal_packer.sv
// Packs five output signal slots into CAN data frames, AXI4-Lite set up
`timescale 1ns/1ps

// Overview of operation
// [RULE1] Slot source selectable or left unconnected
// [RULE2] Optional per-slot inversion before encoding
// [RULE3] Seven slot types; undefined adds nothing
// [RULE4] Byte position 1..8; continuous LSB byte
// [RULE5] Discrete bit position 1..8 in byte
// [RULE6] Continuous scaled by nonzero resolution
// [RULE7] Continuous offset subtracted when encoding
// [RULE8] Limits clamp value; max above min
// [RULE9] Discrete fields stay inside their byte
// [RULE10] Period 0..10000 ms; zero means request
// [RULE11] Clamp, offset, divide, write little-endian
module can_output_signal_packer #(
    parameter int MS_TICK_CYCLES = can_pack_pkg::MS_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic [can_pack_pkg::NUM_SRC-1:0][31:0] src_value,
    output logic [can_pack_pkg::FRAME_W-1:0] tx_data,
    output logic tx_valid,
    input wire logic tx_ready
);
    import can_pack_pkg::*;

    typedef struct packed {
        enc_state_t st;
        logic [2:0] slot;
        logic [FRAME_W-1:0] frame;
        logic [15:0] ms_cnt;
        logic [13:0] per_cnt;
        logic req;
        logic [13:0] period;
        logic [15:0] sent;
        logic [NUM_SLOTS-1:0][31:0] cfg;
        logic [NUM_SLOTS-1:0][31:0] res;
        logic [NUM_SLOTS-1:0][31:0] ofs;
        logic [NUM_SLOTS-1:0][31:0] vmax;
        logic [NUM_SLOTS-1:0][31:0] vmin;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic out_valid;
        logic [FRAME_W-1:0] out_data;
    } pack_state_t;

    pack_state_t s_ff;
    pack_state_t nxt_s;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [FRAME_W-1:0] fifo_out_data;
    logic [127:0] enc;
    logic [FRAME_W-1:0] enc_mask;
    logic [FRAME_W-1:0] enc_bits;
    logic [31:0] cur_cfg;
    sig_type_t cur_type;
    logic [5:0] cur_bsh;

    // Byte-lane merge for AXI write strobes
    function automatic logic [31:0] merge(
        input logic [31:0] old,
        input logic [31:0] val,
        input logic [3:0] strb
    );
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = val[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // One slot to a lane mask (upper half) and the bits under it
    function automatic logic [127:0] encode_slot(
        input logic [31:0] cfg,
        input logic [31:0] res,
        input logic [31:0] ofs,
        input logic [31:0] vmax,
        input logic [31:0] vmin,
        input logic [NUM_SRC-1:0][31:0] src
    );
        sig_type_t ty;
        logic [3:0] sel;
        logic [3:0] bpos;
        logic [3:0] bitp;
        logic inv;
        logic signed [31:0] v;
        logic signed [31:0] c;
        logic signed [31:0] q;
        logic [5:0] bsh;
        logic [5:0] fsh;
        logic [7:0] fld;
        logic [7:0] fm;
        logic [63:0] m;
        logic [63:0] b;
        ty = sig_type_t'(cfg[CFG_TYPE_LSB +: CFG_TYPE_W]);
        inv = cfg[CFG_INV_BIT];
        sel = cfg[CFG_SRC_LSB +: CFG_POS_W];
        bpos = cfg[CFG_BYTE_LSB +: CFG_POS_W];
        bitp = cfg[CFG_BIT_LSB +: CFG_POS_W];
        bsh = {bpos[2:0] - 3'h1, 3'h0};
        fsh = bsh + {3'h0, bitp[2:0] - 3'h1};
        v = '0;
        c = '0;
        q = '0;
        fld = '0;
        fm = '0;
        m = '0;
        b = '0;
        // Unconnected or misplaced slots leave the frame alone
        if (sel != 4'h0 && sel <= 4'(NUM_SRC) && bpos >= POS_MIN && bpos <= POS_MAX) begin // RULE1
            v = $signed(src[3'(sel - 4'h1)]);
            case (ty)
                SIG_DISC1, SIG_DISC2, SIG_DISC4: begin
                    if (bitp >= POS_MIN && bitp <= POS_MAX) begin // RULE5
                        fm = (ty == SIG_DISC1) ? FMASK_1 : (ty == SIG_DISC2) ? FMASK_2 : FMASK_4;
                        fld = inv ? ~v[7:0] : v[7:0]; // RULE2
                        // Bits past the byte edge are dropped, not spilled
                        m = (64'(fm) << fsh) & (CMASK_1 << bsh); // RULE9
                        b = (64'(fld & fm) << fsh) & m;
                    end
                end
                SIG_CONT1, SIG_CONT2, SIG_CONT4: begin
                    // Zero resolution or crossed limits would be garbage
                    if (res != '0 && $signed(vmax) > $signed(vmin)) begin // RULE6
                        c = v;
                        if (v > $signed(vmax)) begin // RULE8
                            c = $signed(vmax);
                        end else if (v < $signed(vmin)) begin
                            c = $signed(vmin);
                        end
                        if (inv) begin // RULE2
                            c = $signed(vmax) - (c - $signed(vmin));
                        end
                        q = (c - $signed(ofs)) / $signed(res); // RULE7
                        m = (ty == SIG_CONT1) ? CMASK_1 : (ty == SIG_CONT2) ? CMASK_2 : CMASK_4;
                        m = m << bsh; // RULE4
                        b = (64'($unsigned(q)) << bsh) & m; // RULE11
                    end
                end
                default: begin // RULE3
                    m = '0;
                end
            endcase
        end
        return {m, b};
    endfunction

    // Current slot view, shared by the encoder and the checks
    assign cur_cfg = s_ff.cfg[s_ff.slot];
    assign cur_type = sig_type_t'(cur_cfg[CFG_TYPE_LSB +: CFG_TYPE_W]);
    assign cur_bsh = {cur_cfg[CFG_BYTE_LSB +: 3] - 3'h1, 3'h0};
    assign enc = encode_slot(cur_cfg, s_ff.res[s_ff.slot], s_ff.ofs[s_ff.slot],
                             s_ff.vmax[s_ff.slot], s_ff.vmin[s_ff.slot], src_value);
    assign enc_mask = enc[127:64];
    assign enc_bits = enc[63:0];
    assign fifo_out_ready = !s_ff.out_valid || tx_ready;

    // Frames wait here when the CAN side stalls
    frame_fifo #(
        .WIDTH(FRAME_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_valid(s_ff.st == ST_PUSH),
        .in_ready(fifo_in_ready),
        .in_data(s_ff.frame),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    // Whole next state: bus slave, timer, encoder, output stage
    always_comb begin
        logic start;
        logic tick;
        logic [31:0] wv;
        logic [2:0] sidx;
        logic [2:0] fidx;
        logic [2:0] ridx;
        logic [2:0] rfld;
        start = 1'b0;
        tick = 1'b0;
        wv = '0;
        nxt_s = s_ff;
        sidx = 3'(s_ff.aw_addr[SLOT_LSB +: 3] - 3'h1);
        fidx = s_ff.aw_addr[FLD_LSB +: 3];
        ridx = 3'(araddr[SLOT_LSB +: 3] - 3'h1);
        rfld = araddr[FLD_LSB +: 3];
        // Period timer in milliseconds; zero parks it
        if (s_ff.period != '0) begin // RULE10
            if (s_ff.ms_cnt == 16'(MS_TICK_CYCLES - 1)) begin
                nxt_s.ms_cnt = '0;
                if (s_ff.per_cnt + 14'h1 >= s_ff.period) begin
                    nxt_s.per_cnt = '0;
                    tick = 1'b1;
                end else begin
                    nxt_s.per_cnt = s_ff.per_cnt + 14'h1;
                end
            end else begin
                nxt_s.ms_cnt = s_ff.ms_cnt + 16'h1;
            end
        end else begin
            nxt_s.ms_cnt = '0;
            nxt_s.per_cnt = '0;
        end
        // Frame sequencer, one slot per cycle; later slots win overlaps
        case (s_ff.st)
            ST_IDLE: begin
                if (s_ff.req) begin
                    start = 1'b1;
                    nxt_s.st = ST_ENC;
                    nxt_s.slot = '0;
                    nxt_s.frame = '0;
                end
            end
            ST_ENC: begin
                nxt_s.frame = (s_ff.frame & ~enc_mask) | enc_bits; // RULE11
                if (s_ff.slot == 3'(NUM_SLOTS - 1)) begin
                    nxt_s.st = ST_PUSH;
                end else begin
                    nxt_s.slot = s_ff.slot + 3'h1;
                end
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    nxt_s.st = ST_IDLE;
                    nxt_s.sent = s_ff.sent + 16'h1;
                end
            end
            default: begin
                nxt_s.st = ST_IDLE;
            end
        endcase
        // A new request in the start cycle is kept, not lost
        nxt_s.req = (s_ff.req && !start) || tick;
        // Write channel: address and data in either order
        if (s_ff.bvalid && bready) begin
            nxt_s.bvalid = 1'b0;
        end
        if (awvalid && s_ff.awready) begin
            nxt_s.aw_have = 1'b1;
            nxt_s.aw_addr = awaddr;
        end
        if (wvalid && s_ff.wready) begin
            nxt_s.w_have = 1'b1;
            nxt_s.w_data = wdata;
            nxt_s.w_strb = wstrb;
        end
        if (s_ff.aw_have && s_ff.w_have && !nxt_s.bvalid) begin
            nxt_s.aw_have = 1'b0;
            nxt_s.w_have = 1'b0;
            nxt_s.bvalid = 1'b1;
            nxt_s.bresp = RESP_OKAY;
            if (s_ff.aw_addr == ADDR_CTRL) begin
                wv = merge({18'h0, s_ff.period}, s_ff.w_data, s_ff.w_strb);
                // Out-of-range periods saturate at the top value
                nxt_s.period = (wv > 32'(PERIOD_MAX)) ? PERIOD_MAX : wv[13:0]; // RULE10
            end else if (s_ff.aw_addr == ADDR_REQ) begin
                if (s_ff.w_strb[0] && s_ff.w_data[0]) begin // RULE10
                    nxt_s.req = 1'b1;
                end
            end else if (s_ff.aw_addr[1:0] == 2'h0 && sidx < 3'(NUM_SLOTS)
                         && s_ff.aw_addr[SLOT_LSB +: 3] != 3'h0 && fidx <= FLD_MIN) begin
                case (fidx)
                    FLD_CFG: nxt_s.cfg[sidx] = merge(s_ff.cfg[sidx], s_ff.w_data, s_ff.w_strb);
                    FLD_RES: nxt_s.res[sidx] = merge(s_ff.res[sidx], s_ff.w_data, s_ff.w_strb);
                    FLD_OFS: nxt_s.ofs[sidx] = merge(s_ff.ofs[sidx], s_ff.w_data, s_ff.w_strb);
                    FLD_MAX: nxt_s.vmax[sidx] = merge(s_ff.vmax[sidx], s_ff.w_data, s_ff.w_strb);
                    default: nxt_s.vmin[sidx] = merge(s_ff.vmin[sidx], s_ff.w_data, s_ff.w_strb);
                endcase
            end else begin
                nxt_s.bresp = RESP_SLVERR;
            end
        end
        nxt_s.awready = !nxt_s.aw_have;
        nxt_s.wready = !nxt_s.w_have;
        // Read channel: answer one cycle after the address is taken
        if (s_ff.rvalid && rready) begin
            nxt_s.rvalid = 1'b0;
        end
        if (arvalid && s_ff.arready) begin
            nxt_s.rvalid = 1'b1;
            nxt_s.rresp = RESP_OKAY;
            nxt_s.rdata = '0;
            if (araddr == ADDR_CTRL) begin
                nxt_s.rdata = {18'h0, s_ff.period};
            end else if (araddr == ADDR_REQ) begin
                nxt_s.rdata = {31'h0, s_ff.req};
            end else if (araddr == ADDR_STATUS) begin
                nxt_s.rdata = {16'h0, s_ff.sent};
                nxt_s.rdata[STAT_FULL_BIT] = !fifo_in_ready;
                nxt_s.rdata[STAT_BUSY_BIT] = (s_ff.st != ST_IDLE);
            end else if (araddr[1:0] == 2'h0 && ridx < 3'(NUM_SLOTS)
                         && araddr[SLOT_LSB +: 3] != 3'h0 && rfld <= FLD_MIN) begin
                case (rfld)
                    FLD_CFG: nxt_s.rdata = s_ff.cfg[ridx];
                    FLD_RES: nxt_s.rdata = s_ff.res[ridx];
                    FLD_OFS: nxt_s.rdata = s_ff.ofs[ridx];
                    FLD_MAX: nxt_s.rdata = s_ff.vmax[ridx];
                    default: nxt_s.rdata = s_ff.vmin[ridx];
                endcase
            end else begin
                nxt_s.rresp = RESP_SLVERR;
            end
        end
        nxt_s.arready = !nxt_s.rvalid;
        // Output register keeps tx pins straight off flops
        if (fifo_out_valid && fifo_out_ready) begin
            nxt_s.out_valid = 1'b1;
            nxt_s.out_data = fifo_out_data;
        end else if (tx_ready) begin
            nxt_s.out_valid = 1'b0;
        end
    end

    // Register the state; slot 1 powers up as a live channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
            s_ff.period <= PERIOD_RST;
            s_ff.awready <= 1'b1;
            s_ff.wready <= 1'b1;
            s_ff.arready <= 1'b1;
            for (int i = 0; i < NUM_SLOTS; i++) begin
                s_ff.cfg[i] <= (i == 0) ? CFG1_RST : CFG_RST; // RULE1
                s_ff.res[i] <= (i == 0) ? RES1_RST : RES_RST; // RULE6
                s_ff.vmax[i] <= (i == 0) ? MAX1_RST : MAX_RST; // RULE8
            end
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign awready = s_ff.awready;
    assign wready = s_ff.wready;
    assign bvalid = s_ff.bvalid;
    assign bresp = s_ff.bresp;
    assign arready = s_ff.arready;
    assign rvalid = s_ff.rvalid;
    assign rdata = s_ff.rdata;
    assign rresp = s_ff.rresp;
    assign tx_valid = s_ff.out_valid;
    assign tx_data = s_ff.out_data;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_unconn_silent;
        s_ff.st == ST_ENC && cur_cfg[CFG_SRC_LSB +: CFG_POS_W] == 4'h0 |-> enc_mask == '0;
    endproperty
    a_unconn_silent: assert property (p_unconn_silent) // RULE1
        else $error("unconnected slot touched the frame");

    property p_disc_plain;
        s_ff.st == ST_ENC && cur_type == SIG_DISC1 && !cur_cfg[CFG_INV_BIT] && enc_mask != '0
            |-> (enc_bits != '0) == src_value[3'(cur_cfg[CFG_SRC_LSB +: 3] - 3'h1)][0];
    endproperty
    a_disc_plain: assert property (p_disc_plain) // RULE2
        else $error("non-inverted one-bit field differs from its source");

    property p_undef_silent;
        s_ff.st == ST_ENC && cur_type == SIG_UNDEF |-> enc_mask == '0;
    endproperty
    a_undef_silent: assert property (p_undef_silent) // RULE3
        else $error("undefined slot touched the frame");

    property p_cont_lsb;
        s_ff.st == ST_ENC && cur_type inside {SIG_CONT1, SIG_CONT2, SIG_CONT4}
            && enc_mask != '0 |-> enc_mask[cur_bsh +: 8] == 8'hFF
            && (enc_mask & ((64'h1 << cur_bsh) - 64'h1)) == '0;
    endproperty
    a_cont_lsb: assert property (p_cont_lsb) // RULE4
        else $error("continuous value does not start at its byte");

    property p_disc_in_byte;
        s_ff.st == ST_ENC && cur_type inside {SIG_DISC1, SIG_DISC2, SIG_DISC4}
            |-> (enc_mask & ~(CMASK_1 << cur_bsh)) == '0;
    endproperty
    a_disc_in_byte: assert property (p_disc_in_byte) // RULE5
        else $error("discrete field left its byte");

    property p_zero_res;
        s_ff.st == ST_ENC && s_ff.res[s_ff.slot] == '0 && cur_type[2] |-> enc_mask == '0;
    endproperty
    a_zero_res: assert property (p_zero_res) // RULE6
        else $error("zero resolution slot was encoded");

    property p_bad_limits;
        s_ff.st == ST_ENC && cur_type[2]
            && $signed(s_ff.vmax[s_ff.slot]) <= $signed(s_ff.vmin[s_ff.slot]) |-> enc_mask == '0;
    endproperty
    a_bad_limits: assert property (p_bad_limits) // RULE8
        else $error("slot with crossed limits was encoded");

    property p_send_seq;
        s_ff.st == ST_IDLE && s_ff.req |=> s_ff.st == ST_ENC [*5] ##1 s_ff.st == ST_PUSH;
    endproperty
    a_send_seq: assert property (p_send_seq) // RULE10
        else $error("pending send did not walk all slots");
endmodule

// ===== rtl/can_pack_pkg.sv
// Shared constants and types for the CAN output signal packer
package can_pack_pkg;
    localparam int NUM_SLOTS = 5;
    localparam int NUM_SRC = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int FRAME_W = 64;
    // Timing: clock period and the millisecond period unit
    localparam int CLK_NS = 20;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_NS;
    localparam logic [13:0] PERIOD_MAX = 14'h2710;
    localparam logic [13:0] PERIOD_RST = 14'h0064;
    // Byte addresses of the global registers
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_REQ = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    // Slot n (1..5) sits at n*0x20; field index in addr[4:2]
    localparam int SLOT_LSB = 5;
    localparam int FLD_LSB = 2;
    localparam logic [2:0] FLD_CFG = 3'h0;
    localparam logic [2:0] FLD_RES = 3'h1;
    localparam logic [2:0] FLD_OFS = 3'h2;
    localparam logic [2:0] FLD_MAX = 3'h3;
    localparam logic [2:0] FLD_MIN = 3'h4;
    // Slot configuration word layout
    localparam int CFG_TYPE_LSB = 0;
    localparam int CFG_TYPE_W = 3;
    localparam int CFG_INV_BIT = 3;
    localparam int CFG_SRC_LSB = 4;
    localparam int CFG_BYTE_LSB = 8;
    localparam int CFG_BIT_LSB = 12;
    localparam int CFG_POS_W = 4;
    localparam logic [3:0] POS_MIN = 4'h1;
    localparam logic [3:0] POS_MAX = 4'h8;
    // Status word layout
    localparam int STAT_FULL_BIT = 16;
    localparam int STAT_BUSY_BIT = 17;
    // Reset values; values are in milli signal units
    localparam logic [31:0] CFG1_RST = 32'h0000_1114;
    localparam logic [31:0] CFG_RST = 32'h0000_1100;
    localparam logic [31:0] RES1_RST = 32'h0000_0014;
    localparam logic [31:0] RES_RST = 32'h0000_03E8;
    localparam logic [31:0] MAX1_RST = 32'h0000_1388;
    localparam logic [31:0] MAX_RST = 32'h0000_03E8;
    // Field and lane masks
    localparam logic [7:0] FMASK_1 = 8'h01;
    localparam logic [7:0] FMASK_2 = 8'h03;
    localparam logic [7:0] FMASK_4 = 8'h0F;
    localparam logic [63:0] CMASK_1 = 64'h0000_0000_0000_00FF;
    localparam logic [63:0] CMASK_2 = 64'h0000_0000_0000_FFFF;
    localparam logic [63:0] CMASK_4 = 64'h0000_0000_FFFF_FFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {
        SIG_UNDEF = 3'b000,
        SIG_DISC1 = 3'b001,
        SIG_DISC2 = 3'b010,
        SIG_DISC4 = 3'b011,
        SIG_CONT1 = 3'b100,
        SIG_CONT2 = 3'b101,
        SIG_CONT4 = 3'b110
    } sig_type_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ENC = 2'b01,
        ST_PUSH = 2'b10
    } enc_state_t;
endpackage

// ===== rtl/frame_fifo.sv
// Synchronous valid/ready FIFO holding packed frames
`timescale 1ns/1ps

module frame_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [CW-1:0] cnt;
    } fifo_state_t;
    fifo_state_t s_ff;
    fifo_state_t nxt_s;
    logic push;
    logic pop;

    // Flags straight from the count, so full and empty stay honest
    assign in_ready = (s_ff.cnt != CW'(DEPTH));
    assign out_valid = (s_ff.cnt != '0);
    assign out_data = s_ff.mem[s_ff.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer wrap assumes a power-of-two depth
    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wp] = in_data;
            nxt_s.wp = s_ff.wp + PW'(1);
        end
        if (pop) begin
            nxt_s.rp = s_ff.rp + PW'(1);
        end
        if (push && !pop) begin
            nxt_s.cnt = s_ff.cnt + CW'(1);
        end else if (pop && !push) begin
            nxt_s.cnt = s_ff.cnt - CW'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end
endmodule

// ===== tb/can_rx_model.sv
// Far-side CAN controller model: takes frames promptly, slowly or not at all
`timescale 1ns/1ps
module can_rx_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic stall,
    input wire logic slow,
    output logic tx_ready
);
    logic [7:0] lf_ff;
    // Slow mode accepts only on pseudo-random cycles, to exercise back-pressure
    always_ff @(posedge aclk) begin
        lf_ff <= !aresetn ? 8'hA5 : {lf_ff[6:0], lf_ff[7] ^ lf_ff[5]};
        tx_ready <= aresetn && !stall && (!slow || lf_ff[0]);
    end
endmodule

// ===== tb/tb_can_output_signal_packer.sv
// Self-checking bench for the CAN output signal packer
`timescale 1ns/1ps
module tb_can_output_signal_packer;
    import can_pack_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall, slow, periodic;
    logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_ready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, v, r2;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [NUM_SRC-1:0][31:0] src_value;
    logic [63:0] tx_data, base;
    logic [63:0] exq[$];
    int failures, n_checks, nfr;
    can_output_signal_packer #(.MS_TICK_CYCLES(4)) can_output_signal_packer_i (.*);
    can_rx_model can_rx_model_i (.aclk(aclk), .aresetn(aresetn), .stall(stall),
        .slow(slow), .tx_ready(tx_ready));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Bounded wait for a handshake signal sampled high at an edge
    task automatic wt(ref logic s);
        for (int k = 0; k < 500; k++) begin
            @(posedge aclk);
            if (s === 1'b1) return;
        end
        failures++;
        tally_and_finish();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Address and data may be taken on different edges
        fork
            begin
                wt(awready);
                awvalid <= 1'b0;
            end
            begin
                wt(wready);
                wvalid <= 1'b0;
            end
        join
        wt(bvalid);
        bready <= 1'b0;
        chk("bresp", 64'(er), 64'(bresp));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        wt(arready);
        arvalid <= 1'b0;
        wt(rvalid);
        rready <= 1'b0;
        chk("rresp_rdata", {30'h0, er, e}, {30'h0, rresp, rdata});
    endtask
    // Note the frame, request it, and hold the sources until it is encoded
    task automatic req(input logic [63:0] e);
        exq.push_back(e);
        wr(ADDR_REQ, 32'h1, RESP_OKAY);
        repeat (12) @(posedge aclk);
    endtask
    task automatic drain();
        for (int k = 0; exq.size() > 0; k++) begin
            if (k > 600) wt(periodic);
            @(posedge aclk);
        end
    endtask
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Each accepted frame is compared against the oldest expectation (zero when none is queued), or against base in the periodic phase
    always @(posedge aclk) begin
        if (aresetn && tx_valid && tx_ready) begin
            if (periodic) begin
                nfr++;
                chk("periodic frame", base, tx_data);
            end else if (exq.size() == 0) chk("frame beyond queue", 64'h0, tx_data);
            else chk("tx_data", exq.pop_front(), tx_data);
        end
    end
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, periodic, slow} = '0;
        {awaddr, araddr, wdata, src_value} = '0;
        wstrb = 4'hF;
        stall = 1'b1;
        seed = 32'h9BAA9C54;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        rd(8'h20, CFG1_RST, RESP_OKAY);
        rd(8'h24, RES1_RST, RESP_OKAY);
        rd(8'h40, CFG_RST, RESP_OKAY);
        rd(8'hAC, MAX_RST, RESP_OKAY);
        rd(8'hFC, 32'h0, RESP_SLVERR);
        wr(ADDR_STATUS, 32'h1, RESP_SLVERR);
        // Eight frames wait behind a stalled receiver, then drain slowly in order
        for (int i = 0; i < 8; i++) begin
            v = xs() % 5001;
            src_value[0] <= v;
            req({56'h0, 8'(v / 20)});
        end
        rd(ADDR_STATUS, 32'h8, RESP_OKAY);
        stall <= 1'b0;
        slow <= 1'b1;
        drain();
        r2 = xs();
        src_value[1] <= r2;
        wr(8'h40, 32'h532A, RESP_OKAY);
        wr(8'h60, 32'h1535, RESP_OKAY);
        wr(8'h64, 32'd10, RESP_OKAY);
        wr(8'h68, 32'd100, RESP_OKAY);
        wr(8'h6C, 32'd3000, RESP_OKAY);
        base = {56'h0, 8'(v / 20)} | ({62'h0, ~r2[1:0]} << 20);
        src_value[2] <= 32'd9999;
        req(base | 64'h0122_0000_0000);
        src_value[2] <= -32'sd50;
        req(base | 64'hFFF6_0000_0000);
        // Inverted continuous value mirrors inside its limits
        wr(8'h60, 32'h153D, RESP_OKAY);
        req(base | 64'h0122_0000_0000);
        wr(8'h64, 32'h0, RESP_OKAY);
        req(base);
        // Every type code on slot four, source clamped above its maximum
        src_value[3] <= 32'h3FF;
        for (int t = 0; t < 8; t++) begin
            wr(8'h80, 32'h1740 | t, RESP_OKAY);
            req(base | (64'(4'(32'h0111F310 >> (4 * t))) << 48));
        end
        // Crossed limits leave a continuous slot silent
        wr(8'h90, 32'd1000, RESP_OKAY);
        wr(8'h80, 32'h1744, RESP_OKAY);
        req(base);
        drain();
        periodic = 1'b1;
        wr(ADDR_CTRL, 32'h4E20, RESP_OKAY);
        rd(ADDR_CTRL, 32'(PERIOD_MAX), RESP_OKAY);
        wr(ADDR_CTRL, 32'd3, RESP_OKAY);
        nfr = 0;
        repeat (240) @(posedge aclk);
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        repeat (40) @(posedge aclk);
        chk("period frames", 64'h1, 64'(nfr >= 18 && nfr <= 22));
        tally_and_finish();
    end
endmodule
